// ### include/tlp_cfg.svh
// Constants of the temperature-limit and rails-good register block
// Assumes inclusion by bare name from the comparator and register design files
`ifndef TLP_CFG_SVH
`define TLP_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TLP_ADDR_TRIG 8'h0d
`define TLP_ADDR_LIMITS 8'h0e
`define TLP_ADDR_RAIL 8'h0f
`define TLP_ADDR_REV 8'h10

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TLP_TRIG_RST 8'h20
`define TLP_COLD_RST 4'h7
`define TLP_HOT_RST 4'h8
`define TLP_RAIL_RST 8'h00
`define TLP_RDATA_RST 8'h00
`define TLP_CONV_END_RST 1'b1

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TLP_TRIG_BIT 7
`define TLP_CONV_END_BIT 5
`define TLP_TRIG_RW_MASK 8'h5f
`define TLP_COLD_MSB 7
`define TLP_COLD_LSB 4
`define TLP_HOT_MSB 3
`define TLP_HOT_LSB 0

// ----------------------------------------
// Threshold code to degrees Celsius
// ----------------------------------------
`define TLP_COLD_OFS 10'sd7
`define TLP_HOT_OFS 10'sd42

`endif

// ### include/tlp_pkg.sv
// Types of the temperature-limit and rails-good register block
// Assumes the constants header sits in the include path
package tlp_pkg;

   // ----------------------------------------
   // Threshold pair
   // ----------------------------------------
   typedef struct packed {
      logic [3:0] cold_threshold;
      logic [3:0] hot_threshold;
   } tlp_limits_s;

   // ----------------------------------------
   // Rail regulation flags
   // ----------------------------------------
   typedef struct packed {
      logic boost_pos_ok;
      logic gate_high_pump_ok;
      logic invert_conv_ok;
      logic source_pos_reg_ok;
      logic gate_low_pump_ok;
      logic source_neg_reg_ok;
   } tlp_rail_s;

   // ----------------------------------------
   // Acquisition control
   // ----------------------------------------
   typedef enum logic [1:0] {
      TLP_ACQ_IDLE = 2'b01,
      TLP_ACQ_BUSY = 2'b10
   } tlp_acq_e;

endpackage

// ### rtl/tlp_sync.sv
// Two-stage synchroniser for a group of asynchronous levels
// Assumes inputs come from the analog rail monitors, outside mclk_i
`timescale 1ns/100ps
module tlp_sync #(
   parameter int WIDTH = 6
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Levels
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule

// ### rtl/tlp_temp_cmp.sv
// Hot and cold threshold comparator for a finished temperature reading
// Assumes temp_i is signed degrees Celsius, valid while done_i pulses
`timescale 1ns/100ps
`include "tlp_cfg.svh"
module tlp_temp_cmp
   import tlp_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Reading and limits
   input wire logic done_i,
   input wire logic signed [7:0] temp_i,
   input wire tlp_limits_s limits_i,
   // Alarm pulses
   output logic cold_o,
   output logic hot_o
);

   // ----------------------------------------
   // Threshold decode
   // ----------------------------------------
   wire logic signed [9:0] temp_ext = 10'(temp_i);
   wire logic signed [9:0] cold_deg = $signed({6'h00, limits_i.cold_threshold}) - `TLP_COLD_OFS;
   wire logic signed [9:0] hot_deg = $signed({6'h00, limits_i.hot_threshold}) + `TLP_HOT_OFS;
   wire logic is_cold = (temp_ext <= cold_deg);
   wire logic is_hot = (temp_ext >= hot_deg);

   // ----------------------------------------
   // Alarm pulses
   // ----------------------------------------
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cold_o <= 1'b0;
         hot_o <= 1'b0;
      end else begin
         cold_o <= done_i & is_cold;
         hot_o <= done_i & is_hot;
      end
   end

endmodule

// ### rtl/tlp_regs.sv
// Temperature-limit, trigger, rail status and revision registers
// Assumes a serial-bus decoder on mclk_i gives one-cycle read/write strobes
// Assumes the acquisition engine runs on mclk_i
//
// Operation
// - Cold code n means n-7 C; alarm when reading at or below it
// - Hot code n means n+42 C, reset 8; alarm at or above it
// - Rails-good pin released only when the four gate/source rails are good
// - Rail status bit 7 shows the positive boost converter in regulation
// - Rail status bit 6 shows the gate-high charge pump in regulation
// - Rail status bit 5 shows the inverting converter in regulation
// - Rail status bit 4 shows the source-positive regulator in regulation
// - Rail status bit 3 shows the gate-low charge pump in regulation
// - Rail status bit 1 shows the source-negative regulator; bits 2, 0 zero
// - Rail status is read-only, resets to zero, ignores writes
// - Revision holds major in 7:6, minor in 5:4, version in 3:0
// - Writing trigger one starts acquisition; self-clears on completion; compare uses it
`timescale 1ns/100ps
`include "tlp_cfg.svh"
module tlp_regs
   import tlp_pkg::*;
#(
   parameter logic [1:0] MAJOR_REV = 2'h1, // Arbitrary value
   parameter logic [1:0] MINOR_REV = 2'h2, // Arbitrary value
   parameter logic [3:0] VERSION = 4'h3 // Arbitrary value
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Register access from the serial bus decoder
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Acquisition engine
   output logic acq_start_o,
   input wire logic acq_done_i,
   input wire logic signed [7:0] acq_temp_i,
   // Temperature alarms
   output logic cold_alarm_o,
   output logic hot_alarm_o,
   // Rail monitors
   input wire tlp_rail_s rail_ok_i,
   // Rails-good open-drain pin
   output logic rails_good_pin_o,
   output logic rails_good_pin_oe_o
);

   // ----------------------------------------
   // Rail monitor synchronisation
   // ----------------------------------------
   tlp_rail_s rail_sync;

   tlp_sync #(
      .WIDTH(6)
   ) u_rail_sync (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .async_i(rail_ok_i),
      .sync_o(rail_sync)
   );

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   wire logic sel_trig = (reg_addr_i == `TLP_ADDR_TRIG);
   wire logic sel_limits = (reg_addr_i == `TLP_ADDR_LIMITS);
   wire logic sel_rail = (reg_addr_i == `TLP_ADDR_RAIL);
   wire logic sel_rev = (reg_addr_i == `TLP_ADDR_REV);
   wire logic wr_trig = reg_wr_i & sel_trig;
   wire logic wr_limits = reg_wr_i & sel_limits;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   tlp_limits_s limits_q;
   logic [7:0] trig_misc_q;
   logic [7:0] rail_q;
   tlp_acq_e acq_q;
   tlp_acq_e acq_d;
   logic trig_q;
   logic conv_end_q;
   logic start_q;
   logic pin_oe_q;
   logic pin_q;
   logic [7:0] rdata_q;

   // ----------------------------------------
   // Threshold register
   // ----------------------------------------
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         limits_q.cold_threshold <= `TLP_COLD_RST;
         limits_q.hot_threshold <= `TLP_HOT_RST;
      end else if (wr_limits) begin
         limits_q.cold_threshold <= reg_wdata_i[`TLP_COLD_MSB:`TLP_COLD_LSB];
         limits_q.hot_threshold <= reg_wdata_i[`TLP_HOT_MSB:`TLP_HOT_LSB];
      end
   end

   // ----------------------------------------
   // Acquisition trigger
   // ----------------------------------------
   wire logic trig_set = wr_trig & reg_wdata_i[`TLP_TRIG_BIT];
   wire logic acq_end = (acq_q == TLP_ACQ_BUSY) & acq_done_i;

   always_comb begin
      acq_d = acq_q;
      unique case (acq_q)
         TLP_ACQ_IDLE: begin
            if (trig_set) begin
               acq_d = TLP_ACQ_BUSY;
            end
         end
         TLP_ACQ_BUSY: begin
            if (acq_done_i & ~trig_set) begin
               acq_d = TLP_ACQ_IDLE;
            end
         end
         default: begin
            acq_d = TLP_ACQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         acq_q <= TLP_ACQ_IDLE;
         trig_q <= 1'b0;
         conv_end_q <= `TLP_CONV_END_RST;
         start_q <= 1'b0;
      end else begin
         acq_q <= acq_d;
         trig_q <= trig_set | (trig_q & ~acq_end);
         conv_end_q <= ~trig_set & (conv_end_q | acq_end);
         start_q <= trig_set;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         trig_misc_q <= `TLP_TRIG_RST & `TLP_TRIG_RW_MASK;
      end else if (wr_trig) begin
         trig_misc_q <= reg_wdata_i & `TLP_TRIG_RW_MASK;
      end
   end

   // ----------------------------------------
   // Threshold comparison
   // ----------------------------------------
   tlp_temp_cmp u_temp_cmp (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .done_i(acq_end),
      .temp_i(acq_temp_i),
      .limits_i(limits_q),
      .cold_o(cold_alarm_o),
      .hot_o(hot_alarm_o)
   );

   // ----------------------------------------
   // Rail status register
   // ----------------------------------------
   wire logic [7:0] rail_byte = {
      rail_sync.boost_pos_ok,
      rail_sync.gate_high_pump_ok,
      rail_sync.invert_conv_ok,
      rail_sync.source_pos_reg_ok,
      rail_sync.gate_low_pump_ok,
      1'b0,
      rail_sync.source_neg_reg_ok,
      1'b0
   };

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rail_q <= `TLP_RAIL_RST;
      end else begin
         rail_q <= rail_byte;
      end
   end

   // ----------------------------------------
   // Rails-good pin
   // ----------------------------------------
   wire logic rails_all_good = rail_q[6] & rail_q[4] & rail_q[3] & rail_q[1];

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pin_oe_q <= 1'b1;
         pin_q <= 1'b0;
      end else begin
         pin_oe_q <= ~rails_all_good;
         pin_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   wire logic [7:0] trig_byte = trig_misc_q
      | {trig_q, 1'b0, conv_end_q, 5'h00};
   wire logic [7:0] rev_byte = {MAJOR_REV, MINOR_REV, VERSION};
   wire logic [7:0] rd_mux = sel_trig ? trig_byte
      : sel_limits ? limits_q
      : sel_rail ? rail_q
      : sel_rev ? rev_byte
      : 8'h00;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rdata_q <= `TLP_RDATA_RST;
      end else if (reg_rd_i) begin
         rdata_q <= rd_mux;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign reg_rdata_o = rdata_q;
   assign acq_start_o = start_q;
   assign rails_good_pin_o = pin_q;
   assign rails_good_pin_oe_o = pin_oe_q;

endmodule

// ### bench/tlp_regs_sva.sv
// Port checker of the register block
// Assumes binding onto tlp_regs
`timescale 1ns/100ps
module tlp_regs_sva
   import tlp_pkg::*;
#(
   parameter logic [7:0] REV_ID = 8'h63
) (
   // Watched ports
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic acq_start_o,
   input wire logic acq_done_i,
   input wire logic cold_alarm_o,
   input wire logic hot_alarm_o,
   input wire tlp_rail_s rail_ok_i,
   input wire logic rails_good_pin_o,
   input wire logic rails_good_pin_oe_o
);
   // ------
   // Checks
   // ------
   wire good = rail_ok_i.gate_high_pump_ok & rail_ok_i.source_pos_reg_ok
      & rail_ok_i.gate_low_pump_ok & rail_ok_i.source_neg_reg_ok;
   wire trig = reg_wr_i && reg_addr_i == 8'h0d && reg_wdata_i[7];
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   pin_low_a: assert property (rails_good_pin_o == 1'b0)
      else $error("pin value not low");
   pin_rel_a: assert property (!rails_good_pin_oe_o |-> $past(good, 4))
      else $error("pin released with a rail down");
   pin_drv_a: assert property (!good |-> ##4 rails_good_pin_oe_o)
      else $error("pin not driven with a rail down");
   rail_zero_a: assert property (reg_rd_i && reg_addr_i == 8'h0f |=>
      reg_rdata_o[2] == 1'b0 && reg_rdata_o[0] == 1'b0)
      else $error("unused status bits set");
   rev_read_a: assert property (reg_rd_i && reg_addr_i == 8'h10 |=>
      reg_rdata_o == REV_ID)
      else $error("revision read wrong");
   start_a: assert property (trig |=> acq_start_o)
      else $error("no start pulse");
   start_src_a: assert property (acq_start_o |-> $past(trig))
      else $error("start pulse without trigger");
   alarm_src_a: assert property (cold_alarm_o || hot_alarm_o |-> $past(acq_done_i))
      else $error("alarm without reading");
endmodule

bind tlp_regs tlp_regs_sva tlp_regs_sva_i (.*);

// ### bench/tlp_acq_model.sv
// Acquisition engine model: done pulse some cycles after start
// Assumes start pulses from tlp_regs on mclk_i
`timescale 1ns/100ps
module tlp_acq_model (
   // Clock
   input wire logic mclk_i,
   // Control
   input wire logic start_i,
   input wire logic [3:0] dly_i,
   input wire logic signed [7:0] temp_i,
   // Result
   output logic done_o,
   output logic signed [7:0] temp_o
);
   // ------
   // Engine
   // ------
   logic [3:0] cnt_q = 4'h0;
   initial done_o = 1'b0;
   initial temp_o = 8'sh00;
   always @(posedge mclk_i) begin
      done_o <= 1'b0;
      temp_o <= ~temp_o;
      if (start_i) begin
         cnt_q <= dly_i;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
         if (cnt_q == 4'h1) begin
            done_o <= 1'b1;
            temp_o <= temp_i;
         end
      end
   end
endmodule

// ### bench/tlp_regs_bench.sv
// Self-checking bench of the register block
// Assumes the acquisition model and checker beside it
`timescale 1ns/100ps
module tlp_regs_bench
   import tlp_pkg::*;
;
   // ------
   // Harness
   // ------
   typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} tlp_row_s;
   tlp_row_s rows [9] = '{
      '{1'b0, 8'h0d, 8'h00, 8'h20}, '{1'b0, 8'h0e, 8'h00, 8'h78},
      '{1'b0, 8'h0f, 8'h00, 8'h00}, '{1'b0, 8'h10, 8'h00, 8'h63},
      '{1'b1, 8'h0e, 8'h5a, 8'h5a}, '{1'b1, 8'h0d, 8'h5f, 8'h7f},
      '{1'b1, 8'h0f, 8'hff, 8'h00}, '{1'b1, 8'h10, 8'hff, 8'h63},
      '{1'b1, 8'h20, 8'hff, 8'h00}};
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic start, done, cold, hot, pin, oe;
   logic signed [7:0] temp;
   logic signed [7:0] tset = 8'sh00;
   logic [3:0] dly = 4'h4;
   logic [5:0] r;
   tlp_rail_s rail = 6'h00;
   int num_errors = 0;
   int n_checks = 0;
   always #10 mclk_i = ~mclk_i;
   tlp_regs tlp_regs_i (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
      .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .acq_start_o(start),
      .acq_done_i(done), .acq_temp_i(temp), .cold_alarm_o(cold), .hot_alarm_o(hot),
      .rail_ok_i(rail), .rails_good_pin_o(pin), .rails_good_pin_oe_o(oe));
   tlp_acq_model tlp_acq_model_i (.mclk_i(mclk_i), .start_i(start), .dly_i(dly),
      .temp_i(tset), .done_o(done), .temp_o(temp));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk_i);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk_i);
      rd <= 1'b0;
      @(negedge mclk_i);
      chk(rdata, e);
   endtask
   task automatic acq(input logic signed [7:0] t, input logic c, input logic h,
      input logic [3:0] d);
      int k;
      tset <= t;
      dly <= d;
      wr_reg(8'h0d, 8'h80);
      @(negedge mclk_i);
      chk(start, 8'h01);
      rd_chk(8'h0d, 8'h80);
      k = 0;
      while (done !== 1'b1 && k < 40) begin
         @(posedge mclk_i);
         k++;
      end
      @(negedge mclk_i);
      chk({cold, hot}, {c, h});
      rd_chk(8'h0d, 8'h20);
   endtask
   task automatic end_of_test;
      if (num_errors == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      #100000;
      num_errors++;
      end_of_test;
   end
   initial begin
      repeat (16) @(posedge mclk_i);
      chk(oe, 8'h01);
      rst_i <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
         rd_chk(rows[i].a, rows[i].e);
      end
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk_i);
         rail <= (i == 6) ? 6'h3f : (i == 7) ? 6'h17 : ~(6'h01 << i);
         repeat (6) @(posedge mclk_i);
         r = rail;
         rd_chk(8'h0f, {r[5:1], 1'b0, r[0], 1'b0});
         chk(oe, !(r[4] & r[2] & r[1] & r[0]));
         chk(pin, 8'h00);
      end
      @(posedge mclk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      chk(oe, 8'h01);
      rst_i <= 1'b0;
      rd_chk(8'h0e, 8'h78);
      acq(8'sd0, 1'b1, 1'b0, 4'h1);
      acq(8'sd1, 1'b0, 1'b0, 4'h4);
      acq(8'sd50, 1'b0, 1'b1, 4'hf);
      acq(8'sd49, 1'b0, 1'b0, 4'h4);
      wr_reg(8'h0e, 8'h0f);
      acq(-8'sd7, 1'b1, 1'b0, 4'h4);
      acq(-8'sd6, 1'b0, 1'b0, 4'h4);
      acq(8'sd57, 1'b0, 1'b1, 4'h4);
      acq(8'sd56, 1'b0, 1'b0, 4'h4);
      end_of_test;
   end
endmodule
